/* pud_user_data_memory.sv */
// User data memory: word areas, bit views, I/O scan and initialisation
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pud_user_data_memory #(
	parameter int TICK_CYC = pud_pkg::TICK_FAST_CYC
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Executor access
	input wire logic [3:0] i_area,
	input wire logic [pud_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_bit_mode,
	input wire logic [3:0] i_bit_sel,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_tmr_adv,
	input wire logic [pud_pkg::WORD_W-1:0] i_wdata,
	output logic [pud_pkg::WORD_W-1:0] o_rdata,
	output logic o_busy,
	// Forcing
	input wire logic i_frc_wr,
	input wire logic i_frc_on,
	// Retentive limits and mode
	input wire logic [9:0] i_ret_aux,
	input wire logic [9:0] i_ret_tmr,
	input wire logic [9:0] i_ret_cnt,
	input wire logic [13:0] i_ret_dat,
	input wire logic i_prun,
	input wire logic i_init_req,
	input wire logic i_iload_busy,
	output logic o_init_done,
	// Batch scan
	input wire logic i_scan_start,
	output logic o_scan_stb,
	output logic [7:0] o_scan_addr,
	input wire logic [pud_pkg::WORD_W-1:0] i_bin_data,
	output logic [pud_pkg::WORD_W-1:0] o_bout_data,
	output logic o_scan_done,
	// Direct I/O
	output logic o_din_req,
	output logic [7:0] o_din_addr,
	input wire logic [pud_pkg::WORD_W-1:0] i_din_data,
	output logic o_dout_stb,
	output logic [7:0] o_dout_addr,
	output logic [pud_pkg::WORD_W-1:0] o_dout_data,
	// Timebase
	output logic o_tick_fast,
	output logic o_tick_slow
);
	import pud_pkg::*;

	// ****************
	// Storage
	// ****************
	logic [WORD_W-1:0] bin_mem [NUM_IO];
	logic [WORD_W-1:0] bout_mem [NUM_IO];
	logic [WORD_W-1:0] aux_mem [NUM_AUX];
	logic [WORD_W-1:0] spc_mem [NUM_SPC];
	logic [WORD_W-1:0] tmr_mem [NUM_TMR];
	logic [WORD_W-1:0] cnt_mem [NUM_CNT];
	logic [WORD_W-1:0] dat_mem [NUM_DAT];
	logic [WORD_W-1:0] fil_mem [NUM_FIL];
	logic [WORD_W-1:0] lnk_mem [NUM_LNK];
	logic [WORD_W-1:0] lrl_mem [NUM_LRL];
	logic tmr_rel [NUM_TMR];
	logic cnt_rel [NUM_CNT];
	logic [WORD_W-1:0] idx_reg [NUM_IDX];
	logic [WORD_W-1:0] frc_in [NUM_IO];
	logic [WORD_W-1:0] frc_out [NUM_IO];
	logic [WORD_W-1:0] frc_aux [NUM_AUX];
	logic [WORD_W-1:0] frc_lnk [NUM_LNK_BIT];
	logic [WORD_W-1:0] frc_lrl [NUM_LRL];

	pud_state_e st;
	logic init_pend;
	logic [ADDR_W-1:0] init_idx;
	logic [7:0] scan_idx;
	logic acc_ok;
	logic acc_wr;
	logic acc_rd;
	logic in_rng;
	logic [WORD_W-1:0] cur_word;
	logic [WORD_W-1:0] next_word;
	logic [WORD_W-1:0] frc_word;
	logic [WORD_W-1:0] next_frc;
	logic [WORD_W-1:0] adv_step;
	logic [$clog2(TICK_CYC)-1:0] div_cnt;
	logic [3:0] slow_cnt;
	logic [WORD_W-1:0] acc_fast;
	logic [WORD_W-1:0] acc_slow;
	logic [WORD_W-1:0] el_fast;
	logic [WORD_W-1:0] el_slow;

	// Decimal word number is used as a plain binary index
	function automatic logic [ADDR_W:0] area_size(input logic [3:0] a);
		unique case (a)
			AR_BIN, AR_BOUT, AR_DIN, AR_DOUT, AR_LRL, AR_SPC: area_size = 14'(NUM_IO);
			AR_AUX, AR_TMR, AR_CNT, AR_TREL, AR_CREL: area_size = 14'(NUM_AUX);
			AR_DAT, AR_FIL: area_size = 14'(NUM_DAT);
			AR_LNK: area_size = i_bit_mode ? 14'(NUM_LNK_BIT) : 14'(NUM_LNK);
			AR_IDX: area_size = i_bit_mode ? 14'h0000 : 14'(NUM_IDX);
			default: area_size = 14'h0000;
		endcase
	endfunction

	// Replace one bit, keep the other fifteen
	function automatic logic [WORD_W-1:0] merge_bit(input logic [WORD_W-1:0] w,
		input logic [3:0] b, input logic v);
		logic [WORD_W-1:0] r;
		r = w;
		r[b] = v;
		merge_bit = r;
	endfunction

	assign in_rng = {1'b0, i_addr} < area_size(i_area);
	assign acc_ok = (st == ST_IDLE) || (st == ST_WAIT_IL);
	assign acc_wr = acc_ok && i_wr && in_rng;
	assign acc_rd = acc_ok && i_rd && in_rng;
	assign o_busy = !acc_ok;

	// ****************
	// Word view of the addressed location
	// ****************
	always_comb
	begin
		cur_word = '0;
		frc_word = '0;
		unique case (i_area)
			AR_BIN: cur_word = bin_mem[i_addr[7:0]];
			AR_BOUT, AR_DOUT: cur_word = bout_mem[i_addr[7:0]];
			AR_DIN: cur_word = i_din_data;
			AR_AUX: cur_word = aux_mem[i_addr[8:0]];
			AR_SPC: cur_word = spc_mem[i_addr[7:0]];
			AR_TMR: cur_word = tmr_mem[i_addr[8:0]];
			AR_CNT: cur_word = cnt_mem[i_addr[8:0]];
			AR_DAT: cur_word = dat_mem[i_addr];
			AR_FIL: cur_word = fil_mem[i_addr];
			AR_LNK: cur_word = lnk_mem[i_addr[9:0]];
			AR_LRL: cur_word = lrl_mem[i_addr[7:0]];
			AR_IDX: cur_word = idx_reg[i_addr[1:0]];
			AR_TREL: cur_word = {15'h0000, tmr_rel[i_addr[8:0]]};
			AR_CREL: cur_word = {15'h0000, cnt_rel[i_addr[8:0]]};
			default: cur_word = '0;
		endcase
		unique case (i_area)
			AR_BIN, AR_DIN: frc_word = frc_in[i_addr[7:0]];
			AR_BOUT, AR_DOUT: frc_word = frc_out[i_addr[7:0]];
			AR_AUX: frc_word = frc_aux[i_addr[8:0]];
			AR_LNK: frc_word = frc_lnk[i_addr[8:0]];
			AR_LRL: frc_word = frc_lrl[i_addr[7:0]];
			default: frc_word = '0;
		endcase
	end

	// Relay areas take bit 0 of write data as their state
	assign next_word = (i_bit_mode && i_area != AR_TREL && i_area != AR_CREL) ?
		merge_bit(cur_word, i_bit_sel, i_wdata[0]) : i_wdata;
	assign next_frc = merge_bit(frc_word, i_bit_sel, i_frc_on);
	assign adv_step = (i_addr < ADDR_W'(NUM_TMR_FAST)) ? el_fast : el_slow;

	// ****************
	// Sequencer
	// ****************
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st <= ST_IDLE;
			init_pend <= 1'b1;
			init_idx <= '0;
			scan_idx <= '0;
			o_init_done <= 1'b0;
			o_scan_done <= 1'b0;
		end
		else
		begin
			o_init_done <= 1'b0;
			o_scan_done <= 1'b0;
			if (i_init_req)
				init_pend <= 1'b1;
			unique case (st)
				ST_IDLE:
				begin
					if (init_pend || i_init_req)
						st <= ST_WAIT_IL;
					else if (i_scan_start)
					begin
						st <= ST_SCAN;
						scan_idx <= '0;
					end
				end
				// Initial load must finish before clearing starts
				ST_WAIT_IL:
				begin
					if (!i_iload_busy)
					begin
						st <= ST_INIT;
						init_idx <= '0;
						init_pend <= i_init_req;
					end
				end
				ST_INIT:
				begin
					init_idx <= init_idx + 1'b1;
					if (init_idx == ADDR_W'(NUM_DAT - 1))
					begin
						st <= ST_IDLE;
						o_init_done <= 1'b1;
					end
				end
				ST_SCAN:
				begin
					scan_idx <= scan_idx + 1'b1;
					if (scan_idx == 8'(NUM_IO - 1))
					begin
						st <= ST_IDLE;
						o_scan_done <= 1'b1;
					end
				end
			endcase
		end
	end

	assign o_scan_stb = (st == ST_SCAN);
	assign o_scan_addr = scan_idx;
	assign o_bout_data = bout_mem[scan_idx];
	assign o_din_req = acc_rd && (i_area == AR_DIN);
	assign o_din_addr = i_addr[7:0];

	// ****************
	// Word storage; arrays carry no reset, power-up init walks them
	// ****************
	always_ff @(posedge i_clk_sys)
	begin
		if (st == ST_INIT)
		begin
			if (init_idx < ADDR_W'(NUM_IO))
			begin
				bin_mem[init_idx[7:0]] <= bin_mem[init_idx[7:0]] & frc_in[init_idx[7:0]];
				bout_mem[init_idx[7:0]] <= bout_mem[init_idx[7:0]] & frc_out[init_idx[7:0]];
				lrl_mem[init_idx[7:0]] <= lrl_mem[init_idx[7:0]] & frc_lrl[init_idx[7:0]];
				if (init_idx < ADDR_W'(NUM_SPC_CPU))
					spc_mem[init_idx[7:0]] <= SPC_CPU_INIT;
			end
			if (init_idx < ADDR_W'(NUM_AUX))
			begin
				if (init_idx[9:0] >= i_ret_aux)
					aux_mem[init_idx[8:0]] <= aux_mem[init_idx[8:0]] & frc_aux[init_idx[8:0]];
				if (init_idx[9:0] >= i_ret_tmr)
				begin
					tmr_mem[init_idx[8:0]] <= '0;
					tmr_rel[init_idx[8:0]] <= 1'b0;
				end
				if (init_idx[9:0] >= i_ret_cnt)
				begin
					cnt_mem[init_idx[8:0]] <= '0;
					cnt_rel[init_idx[8:0]] <= 1'b0;
				end
			end
			if (init_idx < ADDR_W'(NUM_LNK_BIT))
				lnk_mem[init_idx[9:0]] <= lnk_mem[init_idx[9:0]] & frc_lnk[init_idx[8:0]];
			else if (init_idx < ADDR_W'(NUM_LNK))
				lnk_mem[init_idx[9:0]] <= '0;
			if (!({1'b0, init_idx} < i_ret_dat ||
				(i_prun && init_idx < ADDR_W'(NUM_DAT_IL))))
				dat_mem[init_idx] <= '0;
		end
		else if (st == ST_SCAN)
			bin_mem[scan_idx] <= i_bin_data;
		else if (acc_wr)
		begin
			unique case (i_area)
				AR_BIN: bin_mem[i_addr[7:0]] <= next_word;
				AR_BOUT, AR_DOUT: bout_mem[i_addr[7:0]] <= next_word;
				AR_AUX: aux_mem[i_addr[8:0]] <= next_word;
				AR_SPC: spc_mem[i_addr[7:0]] <= next_word;
				AR_TMR: tmr_mem[i_addr[8:0]] <= next_word;
				AR_CNT: cnt_mem[i_addr[8:0]] <= next_word;
				AR_DAT: dat_mem[i_addr] <= next_word;
				AR_FIL: fil_mem[i_addr] <= next_word;
				AR_LNK: lnk_mem[i_addr[9:0]] <= next_word;
				AR_LRL: lrl_mem[i_addr[7:0]] <= next_word;
				AR_TREL: tmr_rel[i_addr[8:0]] <= next_word[0];
				AR_CREL: cnt_rel[i_addr[8:0]] <= next_word[0];
				default: ;
			endcase
		end
		else if (acc_ok && i_tmr_adv && i_addr < ADDR_W'(NUM_TMR))
			tmr_mem[i_addr[8:0]] <= tmr_mem[i_addr[8:0]] + adv_step;
	end

	// Force flags survive initialisation
	always_ff @(posedge i_clk_sys)
	begin
		if (acc_ok && i_frc_wr && i_bit_mode && in_rng)
		begin
			unique case (i_area)
				AR_BIN, AR_DIN: frc_in[i_addr[7:0]] <= next_frc;
				AR_BOUT, AR_DOUT: frc_out[i_addr[7:0]] <= next_frc;
				AR_AUX: frc_aux[i_addr[8:0]] <= next_frc;
				AR_LNK: frc_lnk[i_addr[8:0]] <= next_frc;
				AR_LRL: frc_lrl[i_addr[7:0]] <= next_frc;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			idx_reg <= '{default: '0};
		else if (st == ST_INIT)
			idx_reg <= '{default: '0};
		else if (acc_wr && i_area == AR_IDX)
			idx_reg[i_addr[1:0]] <= next_word;
	end

	// ****************
	// Read port and direct output
	// ****************
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_rdata <= '0;
		else if (acc_rd && i_bit_mode)
			o_rdata <= {15'h0000, cur_word[i_bit_sel]};
		else if (acc_rd)
			o_rdata <= cur_word;
		else
			o_rdata <= '0;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_dout_stb <= 1'b0;
			o_dout_addr <= '0;
			o_dout_data <= '0;
		end
		else
		begin
			o_dout_stb <= acc_wr && (i_area == AR_DOUT);
			if (acc_wr && i_area == AR_DOUT)
			begin
				o_dout_addr <= i_addr[7:0];
				o_dout_data <= next_word;
			end
		end
	end

	// ****************
	// Timebases; elapsed ticks are frozen per scan
	// ****************
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			div_cnt <= '0;
			slow_cnt <= '0;
			o_tick_fast <= 1'b0;
			o_tick_slow <= 1'b0;
		end
		else
		begin
			o_tick_fast <= (div_cnt == $bits(div_cnt)'(TICK_CYC - 1));
			o_tick_slow <= 1'b0;
			if (div_cnt == $bits(div_cnt)'(TICK_CYC - 1))
			begin
				div_cnt <= '0;
				if (slow_cnt == 4'(SLOW_PER_FAST - 1))
				begin
					slow_cnt <= '0;
					o_tick_slow <= 1'b1;
				end
				else
					slow_cnt <= slow_cnt + 1'b1;
			end
			else
				div_cnt <= div_cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			acc_fast <= '0;
			acc_slow <= '0;
			el_fast <= '0;
			el_slow <= '0;
		end
		else if (st == ST_IDLE && !init_pend && !i_init_req && i_scan_start)
		begin
			el_fast <= acc_fast;
			el_slow <= acc_slow;
			acc_fast <= {15'h0000, o_tick_fast};
			acc_slow <= {15'h0000, o_tick_slow};
		end
		else
		begin
			acc_fast <= acc_fast + {15'h0000, o_tick_fast};
			acc_slow <= acc_slow + {15'h0000, o_tick_slow};
		end
	end

	// ****************
	// Checks
	// ****************
	sequence s_dout_wr;
		acc_wr && i_area == AR_DOUT;
	endsequence
	sequence s_scan_go;
		st == ST_IDLE && !init_pend && !i_init_req && i_scan_start;
	endsequence
	property p_dout_now;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_dout_wr |=> o_dout_stb && o_dout_addr == $past(i_addr[7:0]);
	endproperty
	a_dout_now: assert property (p_dout_now) else $error("direct out not sent");
	property p_dout_word;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_dout_wr and i_bit_mode |=> (o_dout_data ^ $past(cur_word)) ==
			($past(cur_word ^ merge_bit(cur_word, i_bit_sel, i_wdata[0])));
	endproperty
	a_dout_word: assert property (p_dout_word) else $error("dout word wrong");
	property p_din;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		acc_rd && i_area == AR_DIN && !i_bit_mode |-> o_din_req ##1 o_rdata == $past(i_din_data);
	endproperty
	a_din: assert property (p_din) else $error("direct in not fetched");
	property p_scan;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_scan_go |=> o_scan_stb [*8] ##[248:248] o_scan_stb ##1 o_scan_done;
	endproperty
	a_scan: assert property (p_scan) else $error("scan length wrong");
	property p_bit_rd;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		acc_rd && i_bit_mode |=> o_rdata[15:1] == 15'h0000 &&
			o_rdata[0] == $past(cur_word[i_bit_sel]);
	endproperty
	a_bit_rd: assert property (p_bit_rd) else $error("bit read wrong");
	property p_il_first;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		st == ST_WAIT_IL && i_iload_busy |=> st == ST_WAIT_IL;
	endproperty
	a_il_first: assert property (p_il_first) else $error("init before load");
	property p_idx_clr;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		$rose(o_init_done) |-> idx_reg[0] == '0 && idx_reg[1] == '0 && idx_reg[2] == '0;
	endproperty
	a_idx_clr: assert property (p_idx_clr) else $error("index not cleared");
	property p_slow_tick;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_tick_slow |-> o_tick_fast && div_cnt == '0 && slow_cnt == '0 &&
			$past(slow_cnt) == 4'(SLOW_PER_FAST - 1);
	endproperty
	a_slow_tick: assert property (p_slow_tick) else $error("slow tick misplaced");
	property p_bit_wr;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		acc_wr && i_bit_mode && i_area == AR_AUX |=> aux_mem[$past(i_addr[8:0])] ==
			(($past(cur_word) & ~(16'h0001 << $past(i_bit_sel))) |
			(16'($past(i_wdata[0])) << $past(i_bit_sel)));
	endproperty
	a_bit_wr: assert property (p_bit_wr) else $error("bit write spills");
endmodule // pud_user_data_memory
`default_nettype wire

/* pud_pkg.sv */
// Constants for the user data memory of the controller CPU
// What this block does
// - Every word location holds exactly one 16-bit value.
// - Batch/direct input and output word areas span 256 words, 000 to 255.
// - 512 auxiliary, 256 special, 512 timer and 512 counter words.
// - 8192 data words and a separate 8192-word file area.
// - 1024-word link area and 256-word link-relay area.
// - Three unaddressed single-word index registers for indirect addressing.
// - Timers 000-063 step per 0.01 s, the rest per 0.1 s.
// - Word addresses are decimal numbers, not hexadecimal.
// - Bit device is decimal word plus one hex bit digit; ON means 1.
// - Bit 0 is the least significant bit of a numeric word.
// - Timer and counter relay bits follow same-numbered words, 512 each.
// - Link bits alias only the first 512 link words.
// - Direct input is fetched from the module when the instruction executes.
// - Batch inputs load and batch outputs send all together each scan.
// - Direct and batch words at one address map to one module.
// - Direct output writes go to the module immediately.
// - A direct output bit write also sends the other 15 bits.
// - Initialise at power-up and RUN entry; initial load completes first.
// - Forced input, output, link and link-relay bits kept; others cleared.
// - Retentive words from 0 to limit-1 kept; forced auxiliary bits also kept.
// - In protected-run the first 4k data words are always kept.
// - CPU special part reinitialised, user part and files kept, index cleared.
package pud_pkg;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 13;
	localparam int NUM_IO = 256;
	localparam int NUM_AUX = 512;
	localparam int NUM_SPC = 256;
	localparam int NUM_TMR = 512;
	localparam int NUM_CNT = 512;
	localparam int NUM_DAT = 8192;
	localparam int NUM_FIL = 8192;
	localparam int NUM_LNK = 1024;
	localparam int NUM_LNK_BIT = 512;
	localparam int NUM_LRL = 256;
	localparam int NUM_IDX = 3;
	localparam int NUM_DAT_IL = 4096;
	localparam int NUM_TMR_FAST = 64;
	localparam int NUM_SPC_CPU = 128;
	localparam logic [15:0] SPC_CPU_INIT = 16'h0000;
	// Area select codes
	localparam logic [3:0] AR_BIN = 4'h0;
	localparam logic [3:0] AR_BOUT = 4'h1;
	localparam logic [3:0] AR_DIN = 4'h2;
	localparam logic [3:0] AR_DOUT = 4'h3;
	localparam logic [3:0] AR_AUX = 4'h4;
	localparam logic [3:0] AR_SPC = 4'h5;
	localparam logic [3:0] AR_TMR = 4'h6;
	localparam logic [3:0] AR_CNT = 4'h7;
	localparam logic [3:0] AR_DAT = 4'h8;
	localparam logic [3:0] AR_LNK = 4'h9;
	localparam logic [3:0] AR_LRL = 4'ha;
	localparam logic [3:0] AR_FIL = 4'hb;
	localparam logic [3:0] AR_IDX = 4'hc;
	localparam logic [3:0] AR_TREL = 4'hd;
	localparam logic [3:0] AR_CREL = 4'he;
	// Timebases
	localparam int CLK_MHZ = 200;
	localparam int TICK_FAST_US = 10000;
	localparam int TICK_SLOW_US = 100000;
	localparam int TICK_FAST_CYC = TICK_FAST_US * CLK_MHZ;
	localparam int SLOW_PER_FAST = TICK_SLOW_US / TICK_FAST_US;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WAIT_IL = 4'b0010,
		ST_INIT = 4'b0100,
		ST_SCAN = 4'b1000
	} pud_state_e;
endpackage

/* pud_io_model.sv */
// Behavioural input and output modules facing the scan and direct input ports
`timescale 1ns/1ps
`default_nettype none
module pud_io_model (
	// Clock
	input wire logic i_clk_sys,
	// Batch scan
	input wire logic i_scan_stb,
	input wire logic [7:0] i_scan_addr,
	input wire logic [15:0] i_bout_data,
	output logic [15:0] o_bin_data,
	// Direct input
	input wire logic i_din_req,
	input wire logic [7:0] i_din_addr,
	output logic [15:0] o_din_data
);
	// ****************************************
	// Module words
	// ****************************************
	logic [15:0] bout_seen [256];
	logic [15:0] churn = 16'h0000;
	// One value per module, whichever way it is read
	function automatic logic [15:0] modval(input logic [7:0] a);
		return {a, ~a} ^ 16'h3c5a;
	endfunction
	// Unselected lines churn so a stale value never passes
	always @(posedge i_clk_sys)
		churn <= churn + 16'h1357;
	assign o_bin_data = i_scan_stb ? modval(i_scan_addr) : churn;
	assign o_din_data = i_din_req ? modval(i_din_addr) : ~churn;
	always @(posedge i_clk_sys)
		if (i_scan_stb)
			bout_seen[i_scan_addr] <= i_bout_data;
endmodule // pud_io_model
`default_nettype wire

/* tb.sv */
// Self-checking bench for the user data memory
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pud_pkg::*;
	// ****************************************
	// Signals and design
	// ****************************************
	logic i_clk_sys = 0, i_rst_n = 0, i_bit_mode = 0, i_wr = 0, i_rd = 0;
	logic i_frc_wr = 0, i_frc_on = 0, i_prun = 0, i_init_req = 0;
	logic i_iload_busy = 0, i_scan_start = 0, i_tmr_adv = 0;
	logic [3:0] i_area = 0, i_bit_sel = 0;
	logic [12:0] i_addr = 0;
	logic [15:0] i_wdata = 0, v;
	logic [9:0] i_ret_aux = 0, i_ret_tmr = 0, i_ret_cnt = 0;
	logic [13:0] i_ret_dat = 0;
	logic [15:0] o_rdata, o_bout_data, o_dout_data, i_bin_data, i_din_data;
	logic o_busy, o_init_done, o_scan_stb, o_scan_done, o_din_req, o_dout_stb;
	logic o_tick_fast, o_tick_slow;
	logic [7:0] o_scan_addr, o_din_addr, o_dout_addr;
	logic [15:0] mem [int];
	int seed = 41, errors = 0, total_checks = 0, cyc = 0, bad, n, nf, ns;
	logic [3:0] ars [10] = '{AR_AUX, AR_SPC, AR_TMR, AR_CNT, AR_DAT, AR_LNK, AR_LRL,
		AR_FIL, AR_BOUT, AR_IDX};
	int szs [10] = '{NUM_AUX, NUM_SPC, NUM_TMR, NUM_CNT, NUM_DAT, NUM_LNK, NUM_LRL,
		NUM_FIL, NUM_IO, NUM_IDX};
	int rf [4] = '{0, 1, 6, 9};
	always #2.5 i_clk_sys = ~i_clk_sys;
	// Short tick so the timebase is seen within the run
	pud_user_data_memory #(.TICK_CYC(20)) pud_user_data_memory_i (
		.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_area(i_area), .i_addr(i_addr),
		.i_bit_mode(i_bit_mode), .i_bit_sel(i_bit_sel), .i_wr(i_wr), .i_rd(i_rd),
		.i_tmr_adv(i_tmr_adv), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_busy(o_busy),
		.i_frc_wr(i_frc_wr), .i_frc_on(i_frc_on), .i_ret_aux(i_ret_aux),
		.i_ret_tmr(i_ret_tmr), .i_ret_cnt(i_ret_cnt), .i_ret_dat(i_ret_dat),
		.i_prun(i_prun), .i_init_req(i_init_req), .i_iload_busy(i_iload_busy),
		.o_init_done(o_init_done), .i_scan_start(i_scan_start),
		.o_scan_stb(o_scan_stb), .o_scan_addr(o_scan_addr), .i_bin_data(i_bin_data),
		.o_bout_data(o_bout_data), .o_scan_done(o_scan_done), .o_din_req(o_din_req),
		.o_din_addr(o_din_addr), .i_din_data(i_din_data), .o_dout_stb(o_dout_stb),
		.o_dout_addr(o_dout_addr), .o_dout_data(o_dout_data),
		.o_tick_fast(o_tick_fast), .o_tick_slow(o_tick_slow));
	pud_io_model pud_io_model_i (
		.i_clk_sys(i_clk_sys), .i_scan_stb(o_scan_stb), .i_scan_addr(o_scan_addr),
		.i_bout_data(o_bout_data), .o_bin_data(i_bin_data), .i_din_req(o_din_req),
		.i_din_addr(o_din_addr), .o_din_data(i_din_data));
	// ****************************************
	// Tasks
	// ****************************************
	function automatic int k(input logic [3:0] a, input int ad);
		return int'(a) * 16384 + ad;
	endfunction
	function automatic logic [15:0] pat(input logic [7:0] a);
		return {a, ~a} ^ 16'h3c5a;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One access; read data is settled when this returns
	task automatic acc(input logic [3:0] a, input int ad, input logic w, input logic bm,
		input logic [3:0] b, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_area <= a;
		i_addr <= ad[12:0];
		i_bit_mode <= bm;
		i_bit_sel <= b;
		i_wdata <= d;
		i_wr <= w;
		i_rd <= !w;
		@(posedge i_clk_sys);
		i_wr <= 0;
		i_rd <= 0;
		#1;
	endtask
	task automatic wrw(input logic [3:0] a, input int ad, input logic [15:0] d);
		acc(a, ad, 1, 0, 0, d);
		mem[k(a, ad)] = d;
	endtask
	task automatic wrb(input logic [3:0] a, input int ad, input int b, input logic x);
		logic [15:0] t;
		acc(a, ad, 1, 1, b[3:0], {15'h0, x});
		t = mem[k(a, ad)];
		t[b] = x;
		mem[k(a, ad)] = t;
	endtask
	task automatic rdchk(input logic [3:0] a, input int ad);
		acc(a, ad, 0, 0, 0, 0);
		chk(o_rdata, mem[k(a, ad)], "word read");
	endtask
	task automatic dchk(input int ad);
		chk({15'h0, o_dout_stb}, 16'h1, "dout strobe");
		chk({8'h0, o_dout_addr}, ad[15:0], "dout addr");
		chk(o_dout_data, mem[k(AR_DOUT, ad)], "dout word");
	endtask
	task automatic frc(input logic [3:0] a, input int ad, input logic [15:0] m);
		for (int b = 0; b < 16; b++)
		begin
			@(posedge i_clk_sys);
			i_area <= a;
			i_addr <= ad[12:0];
			i_bit_mode <= 1;
			i_bit_sel <= b[3:0];
			i_frc_on <= m[b];
			i_frc_wr <= 1;
		end
		@(posedge i_clk_sys);
		i_frc_wr <= 0;
		i_bit_mode <= 0;
	endtask
	task automatic wait_init;
		n = 0;
		while (o_init_done !== 1'b1 && n < 9000)
		begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		chk({15'h0, o_init_done}, 16'h1, "init end");
	endtask
	task automatic scan_go;
		@(posedge i_clk_sys);
		i_scan_start <= 1;
		@(posedge i_clk_sys);
		i_scan_start <= 0;
		n = 0;
		while (o_scan_done !== 1'b1 && n < 300)
		begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		chk({15'h0, o_scan_done}, 16'h1, "scan end");
	endtask
	task automatic run_init;
		@(posedge i_clk_sys);
		i_iload_busy <= 1;
		i_init_req <= 1;
		@(posedge i_clk_sys);
		i_init_req <= 0;
		bad = 0;
		repeat (40)
		begin
			@(posedge i_clk_sys);
			#1;
			if (o_busy !== 1'b0 || o_init_done !== 1'b0)
				bad++;
		end
		chk(16'(bad), 16'h0, "init during load");
		@(posedge i_clk_sys);
		i_iload_busy <= 0;
		wait_init();
	endtask
	// Hang guard, well above the expected run
	always @(posedge i_clk_sys)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			errors++;
			$display("CHECK FAILED %0t timeout", $time);
			close_out();
		end
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1;
		wait_init();
		$display("test reset done");
		for (int i = 0; i < 10; i++)
		begin
			wrw(ars[i], szs[i] - 1, 16'($random(seed)));
			rdchk(ars[i], szs[i] - 1);
		end
		for (int j = 0; j < 4; j++)
		begin
			acc(ars[rf[j]], szs[rf[j]], 1, 0, 0, 16'hffff);
			acc(ars[rf[j]], szs[rf[j]], 0, 0, 0, 0);
			chk(o_rdata, 16'h0, "refused read");
		end
		$display("test words done");
		wrw(AR_AUX, 7, 16'($random(seed)));
		v = mem[k(AR_AUX, 7)];
		wrb(AR_AUX, 7, 15, ~v[15]);
		wrb(AR_AUX, 7, 0, ~v[0]);
		rdchk(AR_AUX, 7);
		acc(AR_AUX, 7, 0, 1, 4'h0, 0);
		chk(o_rdata, {15'h0, ~v[0]}, "bit read");
		wrw(AR_LNK, 600, 16'($random(seed)));
		v = mem[k(AR_LNK, 600)];
		acc(AR_LNK, 600, 1, 1, 4'h2, {15'h0, ~v[2]});
		rdchk(AR_LNK, 600);
		$display("test bits done");
		wrw(AR_DOUT, 37, 16'($random(seed)));
		dchk(37);
		wrb(AR_DOUT, 37, 4, ~mem[k(AR_DOUT, 37)][4]);
		dchk(37);
		acc(AR_DIN, 9, 0, 0, 0, 0);
		chk(o_rdata, pat(8'd9), "direct in");
		scan_go();
		chk(pud_io_model_i.bout_seen[37], mem[k(AR_DOUT, 37)], "batch out");
		chk(pud_io_model_i.bout_seen[255], mem[k(AR_BOUT, 255)], "batch out");
		acc(AR_BIN, 9, 0, 0, 0, 0);
		chk(o_rdata, pat(8'd9), "batch in");
		acc(AR_BIN, 200, 0, 0, 0, 0);
		chk(o_rdata, pat(8'd200), "batch in");
		$display("test io done");
		nf = 0;
		ns = 0;
		repeat (400)
		begin
			@(posedge i_clk_sys);
			#1;
			nf += int'(o_tick_fast);
			ns += int'(o_tick_slow);
		end
		chk(16'(nf), 16'd20, "fast ticks");
		chk(16'(ns), 16'd2, "slow ticks");
		$display("test ticks done");
		wrw(AR_AUX, 100, 16'hffff);
		frc(AR_AUX, 100, 16'h0008);
		wrw(AR_LNK, 10, 16'h00ff);
		frc(AR_LNK, 10, 16'h0001);
		wrw(AR_AUX, 1, 16'($random(seed)));
		wrw(AR_DAT, 4, 16'($random(seed)));
		wrw(AR_DAT, 5, 16'($random(seed)));
		wrw(AR_FIL, 8000, 16'($random(seed)));
		wrw(AR_IDX, 1, 16'($random(seed)));
		wrw(AR_SPC, 0, 16'($random(seed)));
		wrw(AR_SPC, 200, 16'($random(seed)));
		wrw(AR_TMR, 0, 16'($random(seed)));
		wrw(AR_TMR, 5, 16'($random(seed)));
		wrw(AR_CNT, 3, 16'($random(seed)));
		wrw(AR_TREL, 5, 16'h0001);
		@(posedge i_clk_sys);
		i_ret_dat <= 14'd5;
		i_ret_aux <= 10'd2;
		i_ret_tmr <= 10'd1;
		i_ret_cnt <= 10'd4;
		run_init();
		mem[k(AR_TMR, 5)] = 16'h0;
		mem[k(AR_TREL, 5)] = 16'h0;
		rdchk(AR_TMR, 0);
		rdchk(AR_TMR, 5);
		rdchk(AR_CNT, 3);
		rdchk(AR_TREL, 5);
		mem[k(AR_AUX, 100)] = 16'h0008;
		mem[k(AR_LNK, 10)] = 16'h0001;
		mem[k(AR_DAT, 5)] = 16'h0;
		mem[k(AR_IDX, 1)] = 16'h0;
		mem[k(AR_IDX, 2)] = 16'h0;
		mem[k(AR_SPC, 0)] = SPC_CPU_INIT;
		rdchk(AR_AUX, 100);
		rdchk(AR_AUX, 1);
		rdchk(AR_LNK, 10);
		rdchk(AR_DAT, 4);
		rdchk(AR_DAT, 5);
		rdchk(AR_FIL, 8000);
		rdchk(AR_FIL, 8191);
		rdchk(AR_IDX, 1);
		rdchk(AR_IDX, 2);
		rdchk(AR_SPC, 0);
		rdchk(AR_SPC, 200);
		$display("test init done");
		@(posedge i_clk_sys);
		i_prun <= 1;
		i_ret_dat <= 14'd0;
		i_ret_tmr <= 10'd0;
		wrw(AR_DAT, 4095, 16'($random(seed)));
		wrw(AR_DAT, 4096, 16'($random(seed)));
		run_init();
		mem[k(AR_DAT, 4096)] = 16'h0;
		rdchk(AR_DAT, 4095);
		rdchk(AR_DAT, 4096);
		$display("test protected run done");
		scan_go();
		// Second start lands 400 edges after the first: 20 fast, 2 slow ticks
		repeat (142) @(posedge i_clk_sys);
		scan_go();
		@(posedge i_clk_sys);
		i_addr <= 13'd63;
		i_tmr_adv <= 1;
		@(posedge i_clk_sys);
		i_addr <= 13'd64;
		@(posedge i_clk_sys);
		i_tmr_adv <= 0;
		mem[k(AR_TMR, 63)] = 16'd20;
		mem[k(AR_TMR, 64)] = 16'd2;
		rdchk(AR_TMR, 63);
		rdchk(AR_TMR, 64);
		$display("test timers done");
		close_out();
	end
endmodule // tb
`default_nettype wire
